// file: tef_pkg.sv
/*
 * tef_pkg: constants, field layouts and word builders for the readout
 * event formatter. Assumes a 125 MHz board clock.
 */
package tef_pkg;
    // register offsets, byte addresses
    localparam logic [15:0] OFF_BUF_END = 16'h0ffc;
    localparam logic [15:0] OFF_CTL = 16'h1000;
    localparam logic [15:0] OFF_STAT = 16'h1002;
    localparam logic [15:0] OFF_RELOC = 16'h1004;
    localparam logic [15:0] OFF_GEO = 16'h100e;
    localparam logic [15:0] OFF_CLR = 16'h1016;
    localparam logic [15:0] OFF_EVCNT = 16'h101c;
    localparam logic [15:0] OFF_EVST = 16'h1020;
    localparam logic [15:0] OFF_AFL = 16'h1022;
    localparam logic [15:0] OFF_TEST = 16'h1028;
    localparam logic [15:0] OFF_EVF = 16'h1038;
    localparam logic [15:0] OFF_EVFST = 16'h103c;
    // buffer geometry
    localparam int BUF_DEPTH = 32768;
    localparam int BUF_AW = 15;
    localparam int FULL_MARGIN = 33;
    localparam logic [15:0] FULL_LVL = 16'(BUF_DEPTH - FULL_MARGIN);
    localparam int EVF_DEPTH = 16;
    localparam int EVF_AW = 4;
    // reset values
    localparam logic [15:0] CTL_RST = 16'h0020;
    localparam logic [4:0] GEO_RST = 5'h1f;
    localparam logic [15:0] AFL_RST = 16'h0040;
    // word type tags, bits 31..27
    localparam logic [4:0] TAG_GH = 5'h08;
    localparam logic [4:0] TAG_GT = 5'h10;
    localparam logic [4:0] TAG_TT = 5'h11;
    localparam logic [4:0] TAG_FILL = 5'h18;
    // converter data subtypes, bits 29..27
    localparam logic [2:0] SUB_HDR = 3'h1;
    localparam logic [2:0] SUB_MEAS = 3'h0;
    localparam logic [2:0] SUB_ERR = 3'h4;
    localparam logic [2:0] SUB_TRL = 3'h3;
    // converter word kind on the hit port
    localparam logic [1:0] KIND_MEAS = 2'h0;
    localparam logic [1:0] KIND_HDR = 2'h1;
    localparam logic [1:0] KIND_ERR = 2'h2;
    // error word flags live in bits 14..0
    localparam int ERR_FLAGS_W = 15;
    // time tag lsb and clock period
    localparam int TT_LSB_NS = 800;
    localparam int CLK_NS = 8;
    localparam logic [6:0] TT_DIV = 7'(TT_LSB_NS / CLK_NS);

    // general control layout, bit 0 at the bottom
    typedef struct packed {
        logic [4:0] spare;
        logic meb_wide;
        logic ttag_en;
        logic evf_en;
        logic comp_read;
        logic test_fifo;
        logic nonlinearity_comp;
        logic align64;
        logic empty_event;
        logic termination_source_select;
        logic term_soft;
        logic bus_fault_enable;
    } tef_ctl_s;

    // board status layout, bit 0 at the bottom
    typedef struct packed {
        logic trig_lost;
        logic pair_mode;
        logic [1:0] resolution_code;
        logic drained;
        logic bus_fault_seen;
        logic [3:0] chip_err;
        logic term_on;
        logic hdr_en;
        logic windowed_acquisition_flag;
        logic full;
        logic almost_full;
        logic data_available_flag;
    } tef_stat_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_COLL, ST_TTAG, ST_TRLR, ST_PAD
    } tef_state_e;

    function automatic logic [31:0] tef_gh(logic [21:0] cnt,
                                           logic [4:0] geo);
        return {TAG_GH, cnt, geo};
    endfunction : tef_gh

    function automatic logic [31:0] tef_gt(logic [2:0] st,
                                           logic [15:0] words,
                                           logic [4:0] geo);
        return {TAG_GT, st, 3'h0, words, geo};
    endfunction : tef_gt

    function automatic logic [31:0] tef_data(logic [1:0] kind,
                                             logic [1:0] tdc,
                                             logic [24:0] pay);
        logic [2:0] sub;
        unique case (kind)
            KIND_MEAS: sub = SUB_MEAS;
            KIND_HDR: sub = SUB_HDR;
            KIND_ERR: sub = SUB_ERR;
            default: sub = SUB_TRL;
        endcase
        return {2'b00, sub, tdc, pay};
    endfunction : tef_data
endpackage : tef_pkg

// file: tef_formatter.sv
/*
 * tef_formatter: frames converter hits into tagged buffer words, holds the
 * output buffer, the event word fifo and the control/status registers.
 * Assumes single-cycle read/write strobes from the bus interface logic and
 * converter words delivered per trigger, closed by hit_end.
 */
`timescale 1ns/1ps
module tef_formatter (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register access
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic reg_berr,
    // readout mode and chained transfer
    input wire logic rd_wide,
    input wire logic cblt_active,
    input wire logic cblt_end,
    // acquisition
    input wire logic trig,
    input wire logic cnt_reset,
    input wire logic windowed_acquisition_flag,
    input wire logic hdr_en,
    input wire logic pair_mode,
    input wire logic [1:0] resolution_code,
    input wire logic [3:0] chip_err,
    // converter words
    input wire logic hit_valid,
    input wire logic [1:0] hit_kind,
    input wire logic [1:0] hit_tdc,
    input wire logic [24:0] hit_data,
    input wire logic hit_end,
    output logic hit_ready,
    // terminations and nonlinearity compensation
    input wire logic term_switch,
    output logic term_on,
    output logic nonlinearity_en
);
    import tef_pkg::*;

    typedef struct packed {
        tef_state_e st;
        logic [15:0] wp;
        logic [15:0] rp;
        logic [15:0] cm;
        logic [15:0] es;
        logic [15:0] words;
        logic [21:0] cnt;
        logic [15:0] stored;
        tef_ctl_s ctl;
        logic [4:0] geo;
        logic [15:0] afl;
        logic [15:0] reloc;
        logic bseen;
        logic lseen;
        logic done;
        logic ev_lost;
        logic ev_ovf;
        logic ev_err;
        logic [6:0] tdiv;
        logic [26:0] tt;
        logic [26:0] ttl;
        logic ack;
        logic berr;
        logic bsel;
        logic [31:0] rdata;
        logic [EVF_AW:0] fw;
        logic [EVF_AW:0] fr;
    } tef_state_s;

    tef_state_s s, n;
    logic [31:0] mem [BUF_DEPTH];
    logic [31:0] evf_mem [EVF_DEPTH];
    logic [31:0] memq;
    logic mem_we, evf_we, rd_buf, clr, wrote, pad;
    logic [31:0] mem_wd;
    logic [15:0] used, tot;
    tef_stat_s stat;

    // fill levels and status word
    assign used = s.wp - s.rp;
    always_comb begin
        stat = '0;
        stat.data_available_flag = (s.rp != s.cm);
        stat.almost_full = (used >= s.afl);
        stat.full = (used >= FULL_LVL);
        stat.windowed_acquisition_flag = windowed_acquisition_flag;
        stat.hdr_en = hdr_en;
        stat.term_on = term_on;
        stat.chip_err = chip_err;
        stat.bus_fault_seen = s.bseen;
        stat.drained = (s.rp == s.cm) | s.done;
        stat.resolution_code = resolution_code;
        stat.pair_mode = pair_mode;
        stat.trig_lost = s.lseen;
    end

    // terminations follow the switch unless software owns them
    assign term_on = s.ctl.termination_source_select ? s.ctl.term_soft
                                                     : term_switch;
    assign nonlinearity_en = s.ctl.nonlinearity_comp;
    assign hit_ready = (s.st == ST_COLL) |
                       (!windowed_acquisition_flag && s.st == ST_IDLE);
    assign reg_ack = s.ack;
    assign reg_berr = s.berr;
    assign reg_rdata = s.bsel ? memq : s.rdata;
    assign tot = s.words + 16'h1;
    assign pad = tot[0] && ((s.ctl.align64 && !rd_wide) ||
                 (s.ctl.bus_fault_enable && rd_wide));

    // next state: register access first, then framing
    always_comb begin
        n = s;
        mem_we = 1'b0;
        mem_wd = '0;
        evf_we = 1'b0;
        rd_buf = 1'b0;
        clr = 1'b0;
        wrote = 1'b0;
        n.ack = 1'b0;
        n.berr = 1'b0;
        n.bsel = 1'b0;
        // a trailer leaving the buffer retires one stored event
        if (s.bsel && memq[31:27] == TAG_GT)
            n.stored = s.stored - 16'h1;
        // chained transfer bookkeeping
        if (cblt_end)
            n.done = 1'b0;
        else if (cblt_active && s.rp == s.cm)
            n.done = 1'b1;
        // register reads
        if (reg_rd) begin
            n.rdata = '0;
            if (reg_addr <= OFF_BUF_END) begin
                if (s.rp != s.cm) begin
                    rd_buf = 1'b1;
                    n.rp = s.rp + 16'h1;
                    n.bsel = 1'b1;
                    n.ack = 1'b1;
                end else if (s.ctl.bus_fault_enable) begin
                    n.berr = 1'b1;
                    n.bseen = 1'b1;
                end else begin
                    n.rdata = {TAG_FILL, 27'h0};
                    n.ack = 1'b1;
                end
            end else begin
                n.ack = 1'b1;
                unique case (reg_addr)
                    OFF_CTL: n.rdata = {16'h0, s.ctl};
                    OFF_STAT: begin
                        n.rdata = {16'h0, stat};
                        n.bseen = 1'b0;
                        n.lseen = 1'b0;
                    end
                    OFF_RELOC: n.rdata = {16'h0, s.reloc};
                    OFF_GEO: n.rdata = {27'h0, s.geo};
                    OFF_EVCNT: n.rdata = {10'h0, s.cnt};
                    OFF_EVST: n.rdata = {16'h0, s.stored};
                    OFF_AFL: n.rdata = {16'h0, s.afl};
                    OFF_EVFST: n.rdata = {27'h0, s.fw - s.fr};
                    OFF_EVF: if (s.fw != s.fr) begin
                        n.rdata = evf_mem[s.fr[EVF_AW-1:0]];
                        n.fr = s.fr + 5'h1;
                    end
                    default: begin
                        n.ack = 1'b0;
                        n.berr = 1'b1;
                    end
                endcase
            end
        end
        // register writes; control, geo and level writes clear the board
        if (reg_wr) begin
            n.ack = 1'b1;
            unique case (reg_addr)
                OFF_CTL: begin
                    n.ctl = tef_ctl_s'(reg_wdata[15:0]);
                    clr = 1'b1;
                end
                OFF_GEO: begin
                    n.geo = reg_wdata[4:0];
                    clr = 1'b1;
                end
                OFF_AFL: begin
                    n.afl = reg_wdata[15:0];
                    clr = 1'b1;
                end
                OFF_RELOC: n.reloc = reg_wdata[15:0];
                OFF_CLR: clr = 1'b1;
                OFF_TEST: if (s.ctl.test_fifo && s.st == ST_IDLE) begin
                    mem_we = 1'b1;
                    mem_wd = reg_wdata;
                    n.cm = s.wp + 16'h1;
                end
                default: begin
                    n.ack = 1'b0;
                    n.berr = 1'b1;
                end
            endcase
        end
        // time tag base, one step per 800 ns
        if (cnt_reset) begin
            n.tdiv = '0;
            n.tt = '0;
        end else if (s.tdiv == TT_DIV - 7'h1) begin
            n.tdiv = '0;
            n.tt = s.tt + 27'h1;
        end else begin
            n.tdiv = s.tdiv + 7'h1;
        end
        // a trigger while framing is lost
        if (trig && windowed_acquisition_flag && s.st != ST_IDLE) begin
            n.lseen = 1'b1;
            n.ev_lost = 1'b1;
        end
        // event framing
        unique case (s.st)
            ST_IDLE: begin
                if (trig && windowed_acquisition_flag && !mem_we) begin
                    mem_we = 1'b1;
                    mem_wd = tef_gh(s.cnt + 22'h1, s.geo);
                    n.cnt = s.cnt + 22'h1;
                    n.es = s.wp;
                    n.words = 16'h1;
                    n.ttl = s.tt;
                    n.ev_lost = 1'b0;
                    n.ev_ovf = 1'b0;
                    n.ev_err = 1'b0;
                    n.st = ST_COLL;
                end else if (!windowed_acquisition_flag && hit_valid &&
                             !mem_we && !s.ctl.test_fifo) begin
                    if (stat.full) begin
                        n.ev_ovf = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = tef_data(hit_kind, hit_tdc, hit_data);
                        n.cm = s.wp + 16'h1;
                    end
                end
            end
            ST_COLL: begin
                if (hit_valid && !s.ctl.test_fifo) begin
                    if (stat.full) begin
                        n.ev_ovf = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        wrote = 1'b1;
                        mem_wd = tef_data(hit_kind, hit_tdc, hit_data);
                        n.words = s.words + 16'h1;
                    end
                    if (hit_kind == KIND_ERR && |hit_data[ERR_FLAGS_W-1:0])
                        n.ev_err = 1'b1;
                end
                if (hit_end) begin
                    if (s.words == 16'h1 && !wrote &&
                        !s.ctl.empty_event) begin
                        n.wp = s.es;
                        n.st = ST_IDLE;
                    end else begin
                        n.st = s.ctl.ttag_en ? ST_TTAG : ST_TRLR;
                    end
                end
            end
            ST_TTAG: begin
                mem_we = 1'b1;
                mem_wd = {TAG_TT, s.ttl};
                n.words = s.words + 16'h1;
                n.st = ST_TRLR;
            end
            ST_TRLR: begin
                mem_we = 1'b1;
                mem_wd = tef_gt({s.ev_lost, s.ev_ovf, s.ev_err},
                                tot, s.geo);
                n.st = pad ? ST_PAD : ST_IDLE;
                if (!pad)
                    n.cm = s.wp + 16'h1;
            end
            ST_PAD: begin
                mem_we = 1'b1;
                mem_wd = {TAG_FILL, 27'h0};
                n.cm = s.wp + 16'h1;
                n.st = ST_IDLE;
            end
        endcase
        if (mem_we)
            n.wp = s.wp + 16'h1;
        // event committed: count it and log it
        if ((s.st == ST_TRLR && !pad) || s.st == ST_PAD) begin
            n.stored = n.stored + 16'h1;
            if (s.ctl.evf_en && (s.fw - s.fr) != 5'(EVF_DEPTH))
                evf_we = 1'b1;
        end
        if (evf_we)
            n.fw = s.fw + 5'h1;
        if (clr) begin
            n.wp = '0;
            n.rp = '0;
            n.cm = '0;
            n.cnt = '0;
            n.stored = '0;
            n.fw = '0;
            n.fr = '0;
            n.st = ST_IDLE;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.ctl <= tef_ctl_s'(CTL_RST);
            s.geo <= GEO_RST;
            s.afl <= AFL_RST;
        end else begin
            s <= n;
        end
    end

    // buffer and event fifo storage
    always_ff @(posedge mclk) begin
        if (mem_we && !clr)
            mem[s.wp[BUF_AW-1:0]] <= mem_wd;
        if (rd_buf)
            memq <= mem[s.rp[BUF_AW-1:0]];
        if (evf_we)
            evf_mem[s.fw[EVF_AW-1:0]] <= {s.cnt[15:0], tot};
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    hdr_tag_a: assert property (
        s.st == ST_IDLE && trig && windowed_acquisition_flag && !reg_wr
        |-> mem_we && mem_wd[31:27] == TAG_GH && n.st == ST_COLL)
        else $error("header word not written on trigger");
    trl_word_a: assert property (
        s.st == ST_TRLR |-> mem_wd[31:27] == TAG_GT &&
        mem_wd[20:5] == s.words + 16'h1)
        else $error("trailer tag or word count wrong");
    drop_empty_a: assert property (
        s.st == ST_COLL && hit_end && !hit_valid && s.words == 16'h1 &&
        !s.ctl.empty_event && !reg_wr |=> s.wp == $past(s.es))
        else $error("empty event not dropped");
    fill_read_a: assert property (
        reg_rd && reg_addr <= OFF_BUF_END && s.rp == s.cm &&
        !s.ctl.bus_fault_enable |=> reg_ack && reg_rdata[31:27] == TAG_FILL)
        else $error("empty read did not return filler");
    berr_read_a: assert property (
        reg_rd && reg_addr <= OFF_BUF_END && s.rp == s.cm &&
        s.ctl.bus_fault_enable |=> reg_berr && !reg_ack && s.bseen)
        else $error("empty read did not end in bus error");
    term_pick_a: assert property (
        !s.ctl.termination_source_select |-> term_on == term_switch)
        else $error("software termination used while switch selected");
    stat_clr_a: assert property (
        reg_rd && reg_addr == OFF_STAT && !trig |=> !s.bseen && !s.lseen)
        else $error("status read did not clear flags");
    pad_step_a: assert property (
        s.st == ST_TRLR && pad |=> s.st == ST_PAD ##1 s.st == ST_IDLE)
        else $error("odd event not padded");
    tick_a: assert property (
        !cnt_reset && s.tdiv == TT_DIV - 7'h1 |=> s.tt == $past(s.tt) + 27'h1)
        else $error("time tag did not advance");
    full_lvl_a: assert property (
        used >= FULL_LVL |-> stat.full) else $error("full flag missing");
    ready_a: assert property (
        s.st == ST_TRLR && !pad && !reg_wr |=> stat.data_available_flag)
        else $error("committed event not flagged ready");

    event_done_c: cover property (s.st == ST_TRLR ##1 s.st == ST_IDLE);
    empty_drop_c: cover property (s.st == ST_COLL && hit_end &&
                                  s.words == 16'h1 && !hit_valid);
    berr_c: cover property (reg_berr);
    pad_c: cover property (s.st == ST_PAD);
endmodule : tef_formatter

// file: tef_bus_master.sv
/*
 * tef_bus_master: register bus master model with one access task.
 * Assumes it is called at a falling edge of mclk, one-cycle strobes.
 */
`timescale 1ns/1ps
module tef_bus_master (
    // clock
    input wire logic mclk,
    // bus towards the formatter
    output logic [15:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_berr
);
    // idle bus carries junk, never the last value
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 16'h5a5a;
        reg_wdata = 32'ha5a5a5a5;
    end

    // one access, answer awaited for at most four cycles
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [31:0] wd, output logic [31:0] d,
                        output logic be);
        int n;
        reg_addr = a;
        reg_wdata = wd;
        reg_rd = !w;
        reg_wr = w;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        n = 0;
        while (reg_ack !== 1'b1 && reg_berr !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        d = reg_rdata;
        be = reg_berr;
        reg_addr = ~a;
        reg_wdata = ~wd;
        @(negedge mclk);
    endtask : xfer
endmodule : tef_bus_master

// file: tb_tdc_readout_event_formatter.sv
/*
 * tb_tdc_readout_event_formatter: directed bench for the formatter.
 * Assumes the bus master model drives the register bus at falling edges.
 */
`timescale 1ns/1ps
module tb_tdc_readout_event_formatter;
    import tef_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0;
    logic [15:0] reg_addr;
    logic reg_rd, reg_wr, reg_ack, reg_berr, rb;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic rd_wide = 1'b0, cblt_active = 1'b0, cblt_end = 1'b0;
    logic trig = 1'b0, cnt_reset = 1'b0, win = 1'b1, hdr_en = 1'b1;
    logic pair_mode = 1'b1, term_switch = 1'b0, hit_valid = 1'b0;
    logic [1:0] resolution_code = 2'h2, hit_kind = 2'h0, hit_tdc = 2'h2;
    logic [3:0] chip_err = 4'h5;
    logic [24:0] hit_data = 25'h0;
    logic hit_end = 1'b0, hit_ready, term_on, nonlinearity_en;
    int err_count = 0, checked = 0, cyc = 0;
    localparam logic [31:0] FILL = {TAG_FILL, 27'h0};

    // clock and hang guard
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    tef_bus_master i_bm (.mclk(mclk), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_berr(reg_berr));

    tef_formatter i_dut (.mclk(mclk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_berr(reg_berr), .rd_wide(rd_wide), .cblt_active(cblt_active),
        .cblt_end(cblt_end), .trig(trig), .cnt_reset(cnt_reset),
        .windowed_acquisition_flag(win), .hdr_en(hdr_en),
        .pair_mode(pair_mode), .resolution_code(resolution_code),
        .chip_err(chip_err), .hit_valid(hit_valid), .hit_kind(hit_kind),
        .hit_tdc(hit_tdc), .hit_data(hit_data), .hit_end(hit_end),
        .hit_ready(hit_ready), .term_switch(term_switch),
        .term_on(term_on), .nonlinearity_en(nonlinearity_en));

    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        i_bm.xfer(1'b1, a, v, rv, rb);
    endtask : wr

    // read, expect no bus error and a masked value
    task automatic rdc(input logic [15:0] a, input logic [31:0] e,
                       input logic [31:0] m);
        i_bm.xfer(1'b0, a, 32'h0, rv, rb);
        chk({31'h0, rb}, 32'h0);
        chk(rv & m, e);
    endtask : rdc

    // event word builders from the tag constants
    function automatic logic [31:0] gh(input int n);
        return {TAG_GH, 22'(n), 5'h0a};
    endfunction : gh

    function automatic logic [31:0] gt(input logic [2:0] s, input int w);
        return {TAG_GT, s, 3'h0, 16'(w), 5'h0a};
    endfunction : gt

    // converter word, held until taken
    task automatic hit(input logic [1:0] k, input logic [24:0] p);
        int n;
        hit_valid = 1'b1;
        hit_kind = k;
        hit_data = p;
        n = 0;
        while (hit_ready !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
    endtask : hit

    task automatic ev();
        hit_valid = 1'b0;
        hit_end = 1'b1;
        @(negedge mclk);
        hit_end = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : ev

    task automatic trg();
        trig = 1'b1;
        @(negedge mclk);
        trig = 1'b0;
        @(negedge mclk);
    endtask : trg

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        rdc(OFF_CTL, 32'h0020, 32'hffff);
        chk({31'h0, nonlinearity_en}, 32'h1);
        rdc(OFF_STAT, 32'h6958, 32'hffff);
        rdc(16'h0000, FILL, 32'hffffffff);
        i_bm.xfer(1'b0, 16'h2000, 32'h0, rv, rb);
        chk({31'h0, rb}, 32'h1);
        $display("test 1 done");
        term_switch = 1'b1;
        wr(OFF_CTL, 32'h0020);
        chk({31'h0, term_on}, 32'h1);
        term_switch = 1'b0;
        wr(OFF_CTL, 32'h0022);
        chk({31'h0, term_on}, 32'h0);
        wr(OFF_CTL, 32'h0026);
        chk({31'h0, term_on}, 32'h1);
        wr(OFF_CTL, 32'h0004);
        chk({31'h0, term_on | nonlinearity_en}, 32'h0);
        wr(OFF_CTL, 32'h0020);
        $display("test 2 done");
        wr(OFF_GEO, 32'h000a);
        trg();
        hit(KIND_HDR, 25'h0123456);
        hit(KIND_MEAS, 25'h1abcdef);
        hit(KIND_ERR, 25'h0001000);
        hit(2'h3, 25'h0000004);
        ev();
        rdc(OFF_STAT, 32'h1, 32'h1);
        rdc(16'h0000, gh(1), 32'hffffffff);
        rdc(16'h0004, {2'b00, SUB_HDR, 2'h2, 25'h0123456}, '1);
        rdc(16'h0008, {2'b00, SUB_MEAS, 2'h2, 25'h1abcdef}, '1);
        rdc(16'h000c, {2'b00, SUB_ERR, 2'h2, 25'h0001000}, '1);
        rdc(16'h0010, {2'b00, SUB_TRL, 2'h2, 25'h0000004}, '1);
        rdc(16'h0014, gt(3'h1, 6), 32'hffffffff);
        rdc(16'h0018, FILL, 32'hffffffff);
        $display("test 3 done");
        trg();
        ev();
        rdc(16'h0000, FILL, 32'hffffffff);
        wr(OFF_CTL, 32'h0028);
        trg();
        ev();
        rdc(16'h0000, gh(1), 32'hffffffff);
        rdc(16'h0000, gt(3'h0, 2), 32'hffffffff);
        $display("test 4 done");
        wr(OFF_CTL, 32'h0020);
        trg();
        hit(KIND_MEAS, 25'h0000077);
        hit_valid = 1'b0;
        trg();
        ev();
        rdc(OFF_STAT, 32'h8000, 32'h8000);
        rdc(OFF_STAT, 32'h0000, 32'h8000);
        rdc(16'h0000, gh(1), 32'hffffffff);
        rdc(16'h0000, {2'b00, SUB_MEAS, 2'h2, 25'h77}, '1);
        rdc(16'h0000, gt(3'h4, 3), 32'hffffffff);
        $display("test 5 done");
        wr(OFF_AFL, 32'h0002);
        wr(OFF_CTL, 32'h0030);
        trg();
        hit(KIND_MEAS, 25'h0000011);
        ev();
        rdc(OFF_STAT, 32'h3, 32'h7);
        trg();
        hit(KIND_MEAS, 25'h0000022);
        ev();
        rdc(16'h0000, gh(1), 32'hffffffff);
        rdc(16'h0000, {2'b00, SUB_MEAS, 2'h2, 25'h11}, '1);
        rdc(16'h0000, gt(3'h0, 3), 32'hffffffff);
        rdc(16'h0000, FILL, 32'hffffffff);
        rdc(16'h0000, gh(2), 32'hffffffff);
        $display("test 6 done");
        wr(OFF_CTL, 32'h0220);
        cnt_reset = 1'b1;
        @(negedge mclk);
        cnt_reset = 1'b0;
        trg();
        hit(KIND_MEAS, 25'h0000033);
        ev();
        rdc(16'h0000, gh(1), 32'hffffffff);
        rdc(16'h0000, {2'b00, SUB_MEAS, 2'h2, 25'h33}, '1);
        rdc(16'h0000, {TAG_TT, 27'h0}, 32'hf8000000);
        rdc(16'h0000, gt(3'h0, 4), 32'hffffffff);
        $display("test 7 done");
        wr(OFF_CTL, 32'h0021);
        i_bm.xfer(1'b0, 16'h0000, 32'h0, rv, rb);
        chk({31'h0, rb}, 32'h1);
        rdc(OFF_STAT, 32'h0400, 32'h0400);
        rdc(OFF_STAT, 32'h0800, 32'h0c00);
        $display("test 8 done");
        win = 1'b0;
        hit(KIND_MEAS, 25'h0000055);
        hit_valid = 1'b0;
        rdc(OFF_STAT, 32'h0001, 32'h0009);
        rdc(16'h0000, {2'b00, SUB_MEAS, 2'h2, 25'h55}, '1);
        $display("test 9 done");
        complete_run();
    end
endmodule : tb_tdc_readout_event_formatter
